// ### common/fast_loop_map.svh
`ifndef FAST_LOOP_MAP_SVH
`define FAST_LOOP_MAP_SVH

// legal range of the serialization factors and of the reference multiplier
`define FL_FACTOR_MIN 4'h4
`define FL_FACTOR_MAX 4'ha

// width of one receive lane on the internal parallel bus
`define FL_LANE_W 8

// reset values of the reconfigurable settings
`define FL_RST_FACTOR0 4'h8
`define FL_RST_FACTOR1 4'ha
`define FL_RST_MULT 4'ha
`define FL_RST_PHASE 4'h0

// matching reference periods needed before lock is declared
`define FL_LOCK_PERIODS 3'h4

// saturation value of the period and gap counters
`define FL_CNT_SAT 5'h1f

`endif

// ### common/fast_loop_pkg.sv
`include "fast_loop_map.svh"

package fast_loop_pkg;

   // factor, multiplier and phase settings share one width
   typedef logic [3:0] factor_type;

   // state of the reference tracking loop
   typedef enum logic [1:0] {
      LK_TRACK = 2'b00,
      LK_LOCKED = 2'b01,
      LK_SWITCH = 2'b10
   } lock_state_type;

   // a factor the counters can serve
   function automatic logic factor_ok(input factor_type f);
      return (f >= `FL_FACTOR_MIN) && (f <= `FL_FACTOR_MAX);
   endfunction : factor_ok

   // bit counter that wraps after f bits
   function automatic factor_type next_count(input factor_type cnt, input factor_type f);
      return (cnt == f - 4'h1) ? 4'h0 : cnt + 4'h1;
   endfunction : next_count

   // word clock high for the first half of the word, rounded up
   function automatic factor_type half_word(input factor_type f);
      return factor_type'((f + 4'h1) >> 1);
   endfunction : half_word

endpackage : fast_loop_pkg

// ### common/loop_clk_if.sv
`timescale 1ns/1ps

interface loop_clk_if #(
   parameter int CHANNELS = 18
);
   logic ref_rise;
   logic [CHANNELS-1:0] ser_bits;
   logic bit_fall;
   logic load_en;

   // synchroniser side: reference edges and retimed serial lanes
   modport sync (output ref_rise, output ser_bits);
   // loop side: consumes edges, produces the bit and word strobes
   modport loop (input ref_rise, input ser_bits, output bit_fall, output load_en);
   // deserializer side
   modport deser (input ser_bits, input bit_fall, input load_en);
endinterface : loop_clk_if

// ### rtl/ref_edge_sync.sv
`timescale 1ns/1ps

module ref_edge_sync #(
   parameter int CHANNELS = 18
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // pins from outside the clock domain
   input wire logic ref_a_in,
   input wire logic ref_b_in,
   input wire logic [CHANNELS-1:0] ser_in,
   // selected reference source
   input wire logic sel_in,
   // retimed results
   loop_clk_if.sync lc
);
   logic [CHANNELS+1:0] meta_r;
   logic [CHANNELS+1:0] sync_r;
   logic ref_d_r;
   wire [CHANNELS+1:0] pins = {ser_in, ref_b_in, ref_a_in};
   // any source may feed either reference pin: another loop, a clock pin, a core signal
   wire ref_cur = sel_in ? sync_r[1] : sync_r[0];

   // two flops on every pin; only sync_r is read by logic
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_r <= '0;
         sync_r <= '0;
         ref_d_r <= 1'b0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
         ref_d_r <= ref_cur;
      end
   end

   // rising edge of the chosen reference, one cycle wide
   assign lc.ref_rise = ref_cur & ~ref_d_r;
   assign lc.ser_bits = sync_r[CHANNELS+1:2];
endmodule : ref_edge_sync

// ### rtl/word_deser.sv
`timescale 1ns/1ps

module word_deser #(
   parameter int CHANNELS = 18,
   parameter int LANE = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // bit and word strobes with the serial lanes
   loop_clk_if.deser lc,
   // parallel bus, lane n at bits 8n+7..8n
   output logic [LANE*CHANNELS-1:0] words_out
);
   logic [9:0] shift_r [CHANNELS];
   logic [9:0] shift_nxt [CHANNELS];

   // the shift register holds at most ten bits
   if (LANE < 1 || LANE > 10 || CHANNELS < 1) begin : g_bad_size
      $error("LANE must be 1 to 10 and CHANNELS at least one");
   end

   generate
      for (genvar n = 0; n < CHANNELS; n++) begin : g_lane
         // oldest bit ends up most significant
         assign shift_nxt[n] = {shift_r[n][8:0], lc.ser_bits[n]};

         // bits are taken only where the serial clock falls
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               shift_r[n] <= 10'h000;
            end else if (lc.bit_fall) begin
               shift_r[n] <= shift_nxt[n];
            end
         end

         // parallel load; no word boundary is promised, the core aligns
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               words_out[LANE*n +: LANE] <= '0;
            end else if (lc.load_en) begin
               words_out[LANE*n +: LANE] <= shift_nxt[n][LANE-1:0];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   property p_fall_sample;
      shift_r[0] != $past(shift_r[0]) |-> $past(lc.bit_fall);
   endproperty
   a_fall_sample: assert property (p_fall_sample) else $error("shift without falling edge");

   property p_lane_map;
      lc.load_en |=> words_out[LANE*CHANNELS-1 -: LANE] == shift_r[CHANNELS-1][LANE-1:0]
         && words_out[LANE-1:0] == shift_r[0][LANE-1:0];
   endproperty
   a_lane_map: assert property (p_lane_map) else $error("lane bits misplaced");
endmodule : word_deser

// ### rtl/fast_loop.sv
`timescale 1ns/1ps
`include "fast_loop_map.svh"

// Function
// - the loop makes both the parallel word clocks and the serial clock for the channels.
// - the internal oscillator runs at the serial bit rate.
// - one serial rate per loop, with up to two factors on the first and second outputs.
// - reference switchover and dynamic reconfiguration stay available in this mode.
// - switchover happens only on a manual request, never on clock loss.
// - the reference may come from another loop, a clock pin or a core signal.
// - a center loop clocks the banks above and below independently; a corner loop one bank.
// - the reference is multiplied by the set multiplier and the word phase is adjustable.
// - each serial bit is captured on the falling edge of the multiplied clock.
// - channel n's byte sits at bus bits 8n+7 down to 8n.
// - the load enable is made automatically with a period set by the factor.
// - the receive factor is one of four to ten bits per word.
module fast_loop #(
   parameter int CHANNELS = 18,
   parameter bit CENTER = 1'b1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // reference clock sources and manual switchover
   input wire logic ref_a_in,
   input wire logic ref_b_in,
   input wire logic ref_switch_req_in,
   // dynamic reconfiguration
   input wire logic cfg_we_in,
   input wire fast_loop_pkg::factor_type cfg_factor0_in,
   input wire fast_loop_pkg::factor_type cfg_factor1_in,
   input wire fast_loop_pkg::factor_type cfg_mult_in,
   input wire fast_loop_pkg::factor_type cfg_phase_in,
   // bank requests
   input wire logic bank_up_en_in,
   input wire logic bank_dn_en_in,
   // serial receive lanes
   input wire logic [CHANNELS-1:0] rx_ser_in,
   // generated clocks and strobes
   output logic hs_clk_out,
   output logic first_factor_clock_output_out,
   output logic second_factor_clock_output_out,
   output logic load_en0_out,
   output logic load_en1_out,
   // bank clock enables
   output logic bank_up_clk_en_out,
   output logic bank_dn_clk_en_out,
   // status
   output logic locked_out,
   output logic ref_sel_out,
   output logic cfg_err_out,
   // parallel receive bus
   output logic [`FL_LANE_W*CHANNELS-1:0] rx_bus_out
);
   import fast_loop_pkg::*;
   localparam int LANE = `FL_LANE_W;
   // refuse sizes the lane map cannot serve
   if (CHANNELS < 1) begin : g_bad_channels
      $error("CHANNELS must be at least one");
   end

   loop_clk_if #(.CHANNELS(CHANNELS)) lc ();
   // settings and their validity
   factor_type factor0_r;
   factor_type factor1_r;
   factor_type mult_r;
   factor_type phase_r;
   logic cfg_err_r;
   wire cfg_ok = factor_ok(cfg_factor0_in) && factor_ok(cfg_factor1_in)
      && factor_ok(cfg_mult_in) && (cfg_phase_in < cfg_factor0_in)
      && (cfg_phase_in < cfg_factor1_in);
   wire cfg_take = cfg_we_in && cfg_ok;
   wire cfg_bad = cfg_we_in && !cfg_ok;

   // serial clock, bit counters and strobes
   logic hs_r;
   factor_type cnt0_r;
   factor_type cnt1_r;
   factor_type cnt0_nxt;
   factor_type cnt1_nxt;
   logic wclk0_r;
   logic wclk1_r;
   logic load0_r;
   logic load1_r;

   // reference tracking
   lock_state_type state_r;
   lock_state_type state_nxt;
   logic [4:0] per_cnt_r;
   logic [4:0] last_per_r;
   logic [2:0] good_r;
   logic locked_r;
   logic sel_r;
   logic bank_up_r;
   logic bank_dn_r;

   // reconfiguration stays open in every state; a bad set is refused whole
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         factor0_r <= `FL_RST_FACTOR0;
         factor1_r <= `FL_RST_FACTOR1;
         mult_r <= `FL_RST_MULT;
         phase_r <= `FL_RST_PHASE;
      end else if (cfg_take) begin
         factor0_r <= cfg_factor0_in;
         factor1_r <= cfg_factor1_in;
         mult_r <= cfg_mult_in;
         phase_r <= cfg_phase_in;
      end
   end

   // error flag holds until the next accepted write
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg_err_r <= 1'b0;
      end else if (cfg_we_in) begin
         cfg_err_r <= cfg_bad;
      end
   end

   // oscillator at the bit rate: high half then low half of each bit
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hs_r <= 1'b0;
      end else begin
         hs_r <= ~hs_r;
      end
   end

   // the serial clock falls at this edge while it is high
   wire bit_fall = hs_r;
   // realign the word phase to the reference while tracking, or on new settings
   wire realign = cfg_take || (lc.ref_rise && state_r == LK_TRACK);
   wire [3:0] phase_src = cfg_take ? cfg_phase_in : phase_r;
   wire last0 = bit_fall && (cnt0_r == factor0_r - 4'h1);
   wire last1 = bit_fall && (cnt1_r == factor1_r - 4'h1);
   wire load0 = last0 && !realign;
   wire load1 = last1 && !realign;

   // both counters share one bit rate, each wraps at its own factor
   assign cnt0_nxt = realign ? phase_src : (bit_fall ? next_count(cnt0_r, factor0_r) : cnt0_r);
   assign cnt1_nxt = realign ? phase_src : (bit_fall ? next_count(cnt1_r, factor1_r) : cnt1_r);

   // strobes to the deserializer
   assign lc.bit_fall = bit_fall;
   assign lc.load_en = load0;

   // bit counters
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt0_r <= 4'h0;
         cnt1_r <= 4'h0;
      end else begin
         cnt0_r <= cnt0_nxt;
         cnt1_r <= cnt1_nxt;
      end
   end

   // word clocks divided from the serial clock; outputs lag the strobes one cycle
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wclk0_r <= 1'b0;
         wclk1_r <= 1'b0;
         load0_r <= 1'b0;
         load1_r <= 1'b0;
      end else begin
         wclk0_r <= cnt0_nxt < half_word(factor0_r);
         wclk1_r <= cnt1_nxt < half_word(factor1_r);
         load0_r <= load0;
         load1_r <= load1;
      end
   end

   // reference period measured in bits
   wire per_match = per_cnt_r == {1'b0, mult_r};
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         per_cnt_r <= 5'h00;
         last_per_r <= 5'h00;
      end else if (lc.ref_rise) begin
         per_cnt_r <= {4'h0, bit_fall};
         last_per_r <= per_cnt_r;
      end else if (bit_fall && per_cnt_r != `FL_CNT_SAT) begin
         per_cnt_r <= per_cnt_r + 5'h01;
      end
   end

   // consecutive matching periods; restarted by any disturbance
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         good_r <= 3'h0;
      end else if (cfg_take || ref_switch_req_in) begin
         good_r <= 3'h0;
      end else if (lc.ref_rise) begin
         good_r <= per_match ? good_r + {2'h0, good_r != `FL_LOCK_PERIODS} : 3'h0;
      end
   end

   // lock tracking; a dead reference only drops lock, it never switches sources
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LK_TRACK: begin
            if (lc.ref_rise && per_match && good_r == `FL_LOCK_PERIODS - 3'h1) begin
               state_nxt = LK_LOCKED;
            end
         end
         LK_LOCKED: begin
            if ((lc.ref_rise && !per_match) || per_cnt_r == `FL_CNT_SAT) begin
               state_nxt = LK_TRACK;
            end
         end
         LK_SWITCH: begin
            if (lc.ref_rise) begin
               state_nxt = LK_TRACK;
            end
         end
         default: begin
            state_nxt = LK_TRACK;
         end
      endcase
      if (cfg_take) begin
         state_nxt = LK_TRACK;
      end
      if (ref_switch_req_in) begin
         state_nxt = LK_SWITCH;
      end
   end

   // state, source select and lock flag
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r <= LK_TRACK;
         sel_r <= 1'b0;
         locked_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sel_r <= sel_r ^ ref_switch_req_in;
         locked_r <= state_nxt == LK_LOCKED;
      end
   end

   // a corner loop never drives the far bank
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bank_up_r <= 1'b0;
         bank_dn_r <= 1'b0;
      end else begin
         bank_up_r <= bank_up_en_in && (state_nxt == LK_LOCKED);
         bank_dn_r <= CENTER && bank_dn_en_in && (state_nxt == LK_LOCKED);
      end
   end

   ref_edge_sync #(.CHANNELS(CHANNELS)) u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ref_a_in(ref_a_in),
      .ref_b_in(ref_b_in),
      .ser_in(rx_ser_in),
      .sel_in(sel_r),
      .lc(lc.sync)
   );

   word_deser #(.CHANNELS(CHANNELS), .LANE(LANE)) u_deser (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .lc(lc.deser),
      .words_out(rx_bus_out)
   );

   // outputs straight from flops
   assign hs_clk_out = hs_r;
   assign first_factor_clock_output_out = wclk0_r;
   assign second_factor_clock_output_out = wclk1_r;
   assign load_en0_out = load0_r;
   assign load_en1_out = load1_r;
   assign bank_up_clk_en_out = bank_up_r;
   assign bank_dn_clk_en_out = bank_dn_r;
   assign locked_out = locked_r;
   assign ref_sel_out = sel_r;
   assign cfg_err_out = cfg_err_r;

   // helper: cycles between load strobes, valid only without realignment
   logic [4:0] gap_r;
   logic clean_r;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gap_r <= 5'h00;
         clean_r <= 1'b0;
      end else begin
         gap_r <= load0_r ? 5'h00 : (gap_r == `FL_CNT_SAT ? gap_r : gap_r + 5'h01);
         clean_r <= ~realign & (load0_r | clean_r);
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   property p_load0_gap;
      load_en0_out && clean_r |-> gap_r == 5'({factor0_r, 1'b0}) - 5'h01;
   endproperty
   a_load0_gap: assert property (p_load0_gap) else $error("load period not factor bits");
   property p_word_clk;
      load_en0_out |-> first_factor_clock_output_out && !$past(first_factor_clock_output_out);
   endproperty
   a_word_clk: assert property (p_word_clk) else $error("word clock not aligned to load");
   property p_second_clk;
      load_en1_out |-> second_factor_clock_output_out;
   endproperty
   a_second_clk: assert property (p_second_clk) else $error("second word clock misaligned");
   property p_clocks_run;
      locked_out && !cfg_we_in |-> ##[1:21] (load_en0_out || !locked_out);
   endproperty
   a_clocks_run: assert property (p_clocks_run) else $error("no word strobe while locked");
   property p_mult_lock;
      locked_out |-> last_per_r == {1'b0, mult_r};
   endproperty
   a_mult_lock: assert property (p_mult_lock) else $error("locked at wrong multiplier");
   property p_bit_rate;
      hs_clk_out |=> !hs_clk_out ##1 hs_clk_out;
   endproperty
   a_bit_rate: assert property (p_bit_rate) else $error("oscillator off bit rate");
   property p_switch_manual;
      ref_sel_out != $past(ref_sel_out) |-> $past(ref_switch_req_in) && !locked_out;
   endproperty
   a_switch_manual: assert property (p_switch_manual) else $error("unrequested switchover");
   property p_cfg_take;
      cfg_we_in |=> (cfg_err_out == !$past(cfg_ok))
         && (factor0_r == ($past(cfg_ok) ? $past(cfg_factor0_in) : $past(factor0_r)));
   endproperty
   a_cfg_take: assert property (p_cfg_take) else $error("reconfiguration mishandled");
   property p_bank;
      bank_dn_clk_en_out |-> CENTER && $past(bank_dn_en_in) && locked_out;
   endproperty
   a_bank: assert property (p_bank) else $error("far bank clocked wrongly");
   c_lock: cover property ($rose(locked_out));
   c_switch: cover property (ref_switch_req_in ##[1:200] $rose(locked_out));
   c_cfg_bad: cover property (cfg_we_in && !cfg_ok);
   c_load_locked: cover property (locked_out && load_en0_out);
endmodule : fast_loop

// ### tb/remote_tx_model.sv
`timescale 1ns/1ps

module remote_tx_model #(
   parameter int CHANNELS = 18
) (
   // source enables
   input wire logic run_a_in,
   input wire logic run_b_in,
   // reference clocks and serial lanes
   output logic ref_a_out,
   output logic ref_b_out,
   output logic [CHANNELS-1:0] ser_out
);
   logic [2:0] bit_idx;
   logic [7:0] pat;

   // reference a frames four bits, msb first; the stream starts mid-word
   initial begin
      ref_a_out = 1'b0;
      ser_out = '0;
      bit_idx = 3'h5;
      #43ns;
      forever begin
         for (int b = 0; b < 4; b++) begin
            ref_a_out = run_a_in && (b < 2);
            for (int n = 0; n < CHANNELS; n++) begin
               pat = 8'h1d ^ 8'(n << 3);
               // idle lanes toggle so a stale level never passes for data
               ser_out[n] = run_a_in ? pat[3'h7 - bit_idx] : ~ser_out[n];
            end
            bit_idx = bit_idx + 3'h1;
            #80ns;
         end
      end
   end

   // second source at an unrelated phase, stands low while stopped
   initial begin
      ref_b_out = 1'b0;
      #97ns;
      forever begin
         ref_b_out = run_b_in;
         #160ns;
         ref_b_out = 1'b0;
         #160ns;
      end
   end
endmodule : remote_tx_model

// ### tb/fast_loop_bench.sv
`timescale 1ns/1ps

module fast_loop_bench;
   import fast_loop_pkg::*;
   localparam int CH = 18;
   localparam time DRV = 1ns;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic run_a = 1'b0;
   logic run_b = 1'b0;
   logic ref_a, ref_b, ref_switch_req_in = 1'b0, cfg_we_in = 1'b0;
   factor_type cfg_factor0_in = 4'h8, cfg_factor1_in = 4'ha;
   factor_type cfg_mult_in = 4'h4, cfg_phase_in = 4'h0;
   logic bank_up_en_in = 1'b0, bank_dn_en_in = 1'b0;
   logic [CH-1:0] ser;
   logic hs_clk_out, ff_out, sf_out, load_en0_out, load_en1_out;
   logic bank_up_clk_en_out, bank_dn_clk_en_out, locked_out, ref_sel_out, cfg_err_out;
   logic [8*CH-1:0] rx_bus_out;
   int failures = 0;
   int n_checks = 0;
   // refused writes as f0, f1, mult, phase nibbles
   localparam logic [15:0] BAD [5] = '{16'h3840, 16'hb840, 16'h8340, 16'h88b0, 16'h8848};

   always #20ns clk_in = ~clk_in;

   remote_tx_model #(.CHANNELS(CH)) remote_tx_model_i (.run_a_in(run_a), .run_b_in(run_b),
      .ref_a_out(ref_a), .ref_b_out(ref_b), .ser_out(ser));

   fast_loop #(.CHANNELS(CH), .CENTER(1'b1)) fast_loop_i (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .ref_a_in(ref_a), .ref_b_in(ref_b),
      .ref_switch_req_in(ref_switch_req_in), .cfg_we_in(cfg_we_in),
      .cfg_factor0_in(cfg_factor0_in), .cfg_factor1_in(cfg_factor1_in),
      .cfg_mult_in(cfg_mult_in), .cfg_phase_in(cfg_phase_in), .bank_up_en_in(bank_up_en_in),
      .bank_dn_en_in(bank_dn_en_in), .rx_ser_in(ser), .hs_clk_out(hs_clk_out),
      .first_factor_clock_output_out(ff_out), .second_factor_clock_output_out(sf_out),
      .load_en0_out(load_en0_out), .load_en1_out(load_en1_out),
      .bank_up_clk_en_out(bank_up_clk_en_out), .bank_dn_clk_en_out(bank_dn_clk_en_out),
      .locked_out(locked_out), .ref_sel_out(ref_sel_out), .cfg_err_out(cfg_err_out),
      .rx_bus_out(rx_bus_out));

   // single comparison point, counts every call
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // every drive lands a fixed delay after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #DRV;
   endtask : step

   function automatic logic [7:0] rotl(input logic [7:0] p, input int k);
      logic [15:0] d;
      d = {p, p} << k;
      return d[15:8];
   endfunction : rotl

   task automatic cfg_write(input factor_type f0, f1, m, ph);
      cfg_factor0_in = f0;
      cfg_factor1_in = f1;
      cfg_mult_in = m;
      cfg_phase_in = ph;
      cfg_we_in = 1'b1;
      step(1);
      cfg_we_in = 1'b0;
      step(1);
   endtask : cfg_write

   task automatic wait_locked();
      int i;
      for (i = 0; i < 400 && locked_out !== 1'b1; i++) begin
         step(1);
      end
      if (i == 400) begin
         check({31'h0, locked_out}, 32'h1);
         print_verdict();
      end
   endtask : wait_locked

   task automatic wait_pulse(input bit second);
      int i;
      for (i = 0; i < 60 && (second ? load_en1_out : load_en0_out) !== 1'b1; i++) begin
         step(1);
      end
      if (i == 60) begin
         check(32'h0, 32'h1);
         print_verdict();
      end
   endtask : wait_pulse

   // period of the load strobe and high time of the word clock, in cycles
   task automatic meas(input bit second, input int f);
      int n;
      int hi;
      n = 0;
      hi = 0;
      wait_pulse(second);
      do begin
         step(1);
         n++;
         if ((second ? sf_out : ff_out) === 1'b1) hi++;
      end while ((second ? load_en1_out : load_en0_out) !== 1'b1 && n < 60);
      check(n, 2 * f);
      check(hi, 2 * ((f + 1) / 2));
   endtask : meas

   // boundary is arbitrary, so lane 0 fixes the rotation and every lane must share it
   task automatic data_map();
      int k;
      logic [7:0] w0;
      cfg_write(4'h8, 4'ha, 4'h4, 4'h0);
      wait_locked();
      repeat (2) begin
         wait_pulse(1'b0);
         w0 = rx_bus_out[7:0];
         k = 0;
         for (int r = 1; r < 8; r++) begin
            if (rotl(8'h1d, r) === w0) k = r;
         end
         check(w0, rotl(8'h1d, k));
         for (int n = 1; n < CH; n++) begin
            check(rx_bus_out[8*n +: 8], rotl(8'h1d ^ 8'(n << 3), k));
         end
         step(1);
      end
   endtask : data_map

   task automatic switchover();
      cfg_write(4'h8, 4'ha, 4'h4, 4'h0);
      check({cfg_err_out, locked_out}, 32'h0);
      wait_locked();
      bank_up_en_in = 1'b1;
      bank_dn_en_in = 1'b1;
      run_b = 1'b1;
      step(2);
      check({bank_up_clk_en_out, bank_dn_clk_en_out}, 32'h3);
      ref_switch_req_in = 1'b1;
      step(1);
      ref_switch_req_in = 1'b0;
      step(1);
      check({ref_sel_out, locked_out, bank_up_clk_en_out, bank_dn_clk_en_out}, 32'h8);
      wait_locked();
      bank_up_en_in = 1'b0;
      step(2);
      check({bank_up_clk_en_out, bank_dn_clk_en_out}, 32'h1);
      // losing the selected source must not move the selection
      run_b = 1'b0;
      step(100);
      check({ref_sel_out, locked_out, bank_dn_clk_en_out}, 32'h4);
      ref_switch_req_in = 1'b1;
      step(1);
      ref_switch_req_in = 1'b0;
      step(1);
      check(ref_sel_out, 32'h0);
      wait_locked();
   endtask : switchover

   // outputs low in reset, then the serial clock toggles and default factors free-run
   task automatic after_reset();
      logic prev;
      step(16);
      check({hs_clk_out, ff_out, load_en0_out, locked_out, cfg_err_out}, 32'h0);
      sys_rst_in = 1'b0;
      step(1);
      for (int i = 0; i < 20; i++) begin
         prev = hs_clk_out;
         step(1);
         check(hs_clk_out, !prev);
      end
      // reference stopped, so nothing realigns the counters
      meas(1'b0, 8);
      meas(1'b1, 10);
   endtask : after_reset

   // a multiplier that disagrees with the reference period never locks
   task automatic wrong_mult();
      int hi_seen;
      run_a = 1'b1;
      cfg_write(4'h8, 4'ha, 4'h5, 4'h0);
      check({cfg_err_out, locked_out}, 32'h0);
      hi_seen = 0;
      for (int i = 0; i < 150; i++) begin
         step(1);
         if (locked_out !== 1'b0) hi_seen++;
      end
      check(hi_seen, 32'h0);
   endtask : wrong_mult

   // every legal factor, paired with a second factor on the other output
   task automatic factor_sweep();
      for (int f = 4; f <= 10; f++) begin
         cfg_write(factor_type'(f), factor_type'(14 - f), 4'h4, 4'h0);
         check({cfg_err_out, locked_out}, 32'h0);
         wait_locked();
         meas(1'b0, f);
         meas(1'b1, 14 - f);
      end
   endtask : factor_sweep

   // refused writes leave the last good settings running
   task automatic bad_writes();
      foreach (BAD[i]) begin
         cfg_write(BAD[i][15:12], BAD[i][11:8], BAD[i][7:4], BAD[i][3:0]);
         check(cfg_err_out, 32'h1);
      end
      wait_locked();
      meas(1'b0, 10);
   endtask : bad_writes

   initial begin
      after_reset();
      wrong_mult();
      data_map();
      factor_sweep();
      bad_writes();
      switchover();
      print_verdict();
   end
endmodule : fast_loop_bench
